// *** scwol_pkg.sv ***
package scwol_pkg;

    // register map of the serial port
    localparam logic [6:0] ADDR_CONTROL_FUNCTION_ONE = 7'h00;
    localparam logic [31:0] CF1_RESET = 32'h0001_0000;
    // writable bits: 16, 15..11, 9..5, 3, 1, 0
    localparam logic [31:0] CF1_WMASK = 32'h0001_FBEB;

    // control_function_one field positions
    localparam int BIT_SINE = 16;
    localparam int BIT_RR_RELOAD = 15;
    localparam int BIT_RAMP_AUTOCLR = 14;
    localparam int BIT_PHASE_AUTOCLR = 13;
    localparam int BIT_RAMP_CLR = 12;
    localparam int BIT_PHASE_CLR = 11;
    localparam int BIT_KEY_AUTO = 9;
    localparam int BIT_KEY_EN = 8;
    localparam int BIT_CORE_PD = 7;
    localparam int BIT_CONV_PD = 6;
    localparam int BIT_REF_PD = 5;
    localparam int BIT_EXT_FAST = 3;
    localparam int BIT_SDIO_IN_ONLY = 1;
    localparam int BIT_LSB_FIRST = 0;

    // serial frame layout
    localparam int INSTR_BITS = 8;
    localparam int DATA_BITS = 32;
    localparam int BIT_RD = 7;

    // synchronisation clock divider default (system clocks per period)
    localparam int SYNC_DIV_DEF = 4;
    localparam int SYNC_CNT_W = 8;

    typedef enum logic [1:0] {
        SP_INSTR,
        SP_DATA,
        SP_DONE
    } scwol_sp_t;

endpackage

// *** scwol_sync.sv ***
`timescale 1ns/10ps
module scwol_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } scwol_sync_st_t;

    scwol_sync_st_t st_r;
    scwol_sync_st_t st_nxt;

    // two flop chain, first stage feeds only the second
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign q = st_r.s2;

endmodule

// *** scwol_upd.sv ***
`timescale 1ns/10ps
module scwol_upd #(
    parameter int SYNC_DIV = scwol_pkg::SYNC_DIV_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic io_update_s,
    input wire logic [2:0] profile_s,
    output logic sync_en,
    output logic xfer
);

    typedef struct packed {
        logic [scwol_pkg::SYNC_CNT_W-1:0] cnt;
        logic upd_q;
        logic [2:0] prof_q;
        logic pend;
        logic sync_en;
        logic xfer;
    } scwol_upd_st_t;

    scwol_upd_st_t st_r;
    scwol_upd_st_t st_nxt;
    logic event_hit;

    // sync clock enable, update event capture, transfer on sync edge
    always_comb
    begin
        st_nxt = st_r;
        event_hit = (io_update_s && !st_r.upd_q) ||
                    (profile_s != st_r.prof_q);
        st_nxt.upd_q = io_update_s;
        st_nxt.prof_q = profile_s;
        st_nxt.sync_en = 1'b0;
        st_nxt.xfer = 1'b0;
        if (st_r.cnt == scwol_pkg::SYNC_CNT_W'(SYNC_DIV - 1))
        begin
            st_nxt.cnt = '0;
            st_nxt.sync_en = 1'b1;
            st_nxt.xfer = st_r.pend || event_hit;
            st_nxt.pend = 1'b0;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + scwol_pkg::SYNC_CNT_W'(1);
            st_nxt.pend = st_r.pend || event_hit; // event never lost
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign sync_en = st_r.sync_en;
    assign xfer = st_r.xfer;

endmodule

// *** scwol_ctrl.sv ***
`timescale 1ns/10ps
// Functional notes
// R1: sine output selected when select bit set
// R2: cosine output selected when select bit clear
// R3: ramp-rate reload needs ramp generator enabled
// R4: reload loads ramp rate at each update
// R5: ramp autoclear pulses one sync cycle
// R6: clear bits applied at update, sync edge
// R7: phase autoclear resets phase accumulator each update
// R8: ramp static clear holds ramp accumulator reset
// R9: phase static clear holds phase accumulator reset
// R10: keying mode auto only when keying enabled
// R11: amplitude adjust needs keying enable bit
// R12: digital power-down stops core clocks immediately
// R13: converter power-down disables converter clocks, bias
// R14: reference power-down acts immediately
// R15: external pin selects full or fast power-down
// R16: bit 1 chooses two-wire or three-wire
// R17: bit 0 chooses MSB or LSB first
// R18: control values move only at update events; core_clock_enable and reference_input_powerdown follow buf_w at once
// R19: unused bits 10, 4, 2 read zero
module scwol_ctrl #(
    parameter int SYNC_DIV = scwol_pkg::SYNC_DIV_DEF
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic sdo,
    input wire logic io_update,
    input wire logic [2:0] profile_select,
    input wire logic external_powerdown_pin,
    input wire logic ramp_generator_enable,
    output logic sine_select,
    output logic ramp_rate_load,
    output logic ramp_acc_clear,
    output logic phase_acc_clear,
    output logic keying_enable,
    output logic keying_auto,
    output logic amp_adjust_enable,
    output logic core_clock_enable,
    output logic converter_powerdown,
    output logic reference_input_powerdown,
    output logic full_powerdown,
    output logic fast_powerdown
);

    typedef struct packed {
        logic sclk_q;
        scwol_pkg::scwol_sp_t sp;
        logic [5:0] bitcnt;
        logic rd;
        logic [scwol_pkg::INSTR_BITS-1:0] instr;
        logic [scwol_pkg::DATA_BITS-1:0] shreg;
        logic [scwol_pkg::DATA_BITS-1:0] oreg;
        logic [scwol_pkg::DATA_BITS-1:0] buf_w;
        logic [scwol_pkg::DATA_BITS-1:0] act;
        logic ramp_pulse;
        logic phase_pulse;
        logic sdio_out;
        logic sdio_oe;
        logic sdo;
        logic sine;
        logic rr_load;
        logic ramp_clr;
        logic phase_clr;
        logic key_en;
        logic key_auto;
        logic amp_adj;
        logic core_en;
        logic conv_pd;
        logic ref_pd;
        logic full_pd;
        logic fast_pd;
    } scwol_ctrl_st_t;

    scwol_ctrl_st_t st_r;
    scwol_ctrl_st_t st_nxt;

    logic [7:0] pins_s;
    logic sclk_s;
    logic cs_b_s;
    logic sdi_s;
    logic upd_s;
    logic pd_s;
    logic [2:0] prof_s;
    logic sync_en;
    logic xfer;

    // every pin except ramp_generator_enable, clk and rst_b passes two flops before use
    scwol_sync #(
        .W(8)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d({sclk, cs_b, sdio_in, io_update, external_powerdown_pin,
            profile_select}),
        .q(pins_s)
    );

    assign sclk_s = pins_s[7];
    assign cs_b_s = pins_s[6];
    assign sdi_s = pins_s[5];
    assign upd_s = pins_s[4];
    assign pd_s = pins_s[3];
    assign prof_s = pins_s[2:0];

    // sync clock enable and update transfer timing
    scwol_upd #(
        .SYNC_DIV(SYNC_DIV)
    ) u_upd (
        .clk(clk),
        .rst_b(rst_b),
        .io_update_s(upd_s),
        .profile_s(prof_s),
        .sync_en(sync_en),
        .xfer(xfer)
    );

    logic rise;
    logic fall;
    logic lsb_first;
    logic [scwol_pkg::INSTR_BITS-1:0] ni;
    logic [scwol_pkg::DATA_BITS-1:0] nd;
    logic [scwol_pkg::DATA_BITS-1:0] rdata;

    // serial port, register transfer and output decode
    always_comb
    begin
        st_nxt = st_r;
        rise = sclk_s && !st_r.sclk_q;
        fall = !sclk_s && st_r.sclk_q;
        lsb_first = st_r.act[scwol_pkg::BIT_LSB_FIRST];
        // shift direction follows the bit order
        if (lsb_first) // R17
        begin
            ni = {sdi_s, st_r.instr[scwol_pkg::INSTR_BITS-1:1]};
            nd = {sdi_s, st_r.shreg[scwol_pkg::DATA_BITS-1:1]};
        end
        else
        begin
            ni = {st_r.instr[scwol_pkg::INSTR_BITS-2:0], sdi_s};
            nd = {st_r.shreg[scwol_pkg::DATA_BITS-2:0], sdi_s};
        end
        // unmapped addresses read as zero
        if (ni[6:0] == scwol_pkg::ADDR_CONTROL_FUNCTION_ONE)
            rdata = st_r.buf_w & scwol_pkg::CF1_WMASK; // R19
        else
            rdata = '0;
        st_nxt.sclk_q = sclk_s;
        st_nxt.rr_load = 1'b0;

        // buffered values move to the active copy at update
        if (xfer)
        begin
            st_nxt.act = st_r.buf_w; // R18 R6
            st_nxt.ramp_pulse = st_r.buf_w[scwol_pkg::BIT_RAMP_AUTOCLR]; // R5
            st_nxt.phase_pulse = st_r.buf_w[scwol_pkg::BIT_PHASE_AUTOCLR]; // R7
            st_nxt.rr_load = st_r.buf_w[scwol_pkg::BIT_RR_RELOAD] &&
                             ramp_generator_enable; // R3 R4
        end
        else if (sync_en)
        begin
            st_nxt.ramp_pulse = 1'b0; // R5
            st_nxt.phase_pulse = 1'b0;
        end

        // serial frame: instruction byte, then one data word
        if (cs_b_s)
        begin
            st_nxt.sp = scwol_pkg::SP_INSTR;
            st_nxt.bitcnt = '0;
            st_nxt.sdio_oe = 1'b0;
        end
        else if (rise)
        begin
            case (st_r.sp)
                scwol_pkg::SP_INSTR:
                begin
                    st_nxt.instr = ni;
                    st_nxt.bitcnt = st_r.bitcnt + 6'h01;
                    if (st_r.bitcnt == 6'(scwol_pkg::INSTR_BITS - 1))
                    begin
                        st_nxt.sp = scwol_pkg::SP_DATA;
                        st_nxt.bitcnt = '0;
                        st_nxt.rd = ni[scwol_pkg::BIT_RD];
                        st_nxt.oreg = rdata;
                    end
                end
                scwol_pkg::SP_DATA:
                begin
                    st_nxt.shreg = nd;
                    st_nxt.bitcnt = st_r.bitcnt + 6'h01;
                    if (st_r.bitcnt == 6'(scwol_pkg::DATA_BITS - 1))
                    begin
                        st_nxt.sp = scwol_pkg::SP_DONE;
                        if (!st_r.rd && st_r.instr[6:0] ==
                            scwol_pkg::ADDR_CONTROL_FUNCTION_ONE)
                            st_nxt.buf_w = nd & scwol_pkg::CF1_WMASK; // R19
                    end
                end
                scwol_pkg::SP_DONE:
                begin
                    st_nxt.sp = scwol_pkg::SP_DONE;
                end
                default:
                begin
                    st_nxt.sp = scwol_pkg::SP_INSTR;
                end
            endcase
        end
        else if (fall)
        begin
            // read data changes on the falling edge
            if (st_r.sp == scwol_pkg::SP_DATA && st_r.rd)
            begin
                if (lsb_first) // R17
                begin
                    st_nxt.sdo = st_r.oreg[0];
                    st_nxt.sdio_out = st_r.oreg[0];
                    st_nxt.oreg = {1'b0,
                                   st_r.oreg[scwol_pkg::DATA_BITS-1:1]};
                end
                else
                begin
                    st_nxt.sdo = st_r.oreg[scwol_pkg::DATA_BITS-1];
                    st_nxt.sdio_out = st_r.oreg[scwol_pkg::DATA_BITS-1];
                    st_nxt.oreg = {st_r.oreg[scwol_pkg::DATA_BITS-2:0],
                                   1'b0};
                end
                // two-wire mode turns the data line around
                st_nxt.sdio_oe =
                    !st_r.act[scwol_pkg::BIT_SDIO_IN_ONLY]; // R16
            end
            else
                st_nxt.sdio_oe = 1'b0;
        end

        // registered outputs
        st_nxt.sine = st_nxt.act[scwol_pkg::BIT_SINE]; // R1 R2
        st_nxt.ramp_clr = st_nxt.act[scwol_pkg::BIT_RAMP_CLR] ||
                          st_nxt.ramp_pulse; // R8 R5
        st_nxt.phase_clr = st_nxt.act[scwol_pkg::BIT_PHASE_CLR] ||
                           st_nxt.phase_pulse; // R9 R7
        st_nxt.key_en = st_nxt.act[scwol_pkg::BIT_KEY_EN]; // R11
        st_nxt.key_auto = st_nxt.act[scwol_pkg::BIT_KEY_EN] &&
                          st_nxt.act[scwol_pkg::BIT_KEY_AUTO]; // R10
        st_nxt.amp_adj = st_nxt.act[scwol_pkg::BIT_KEY_EN]; // R11
        st_nxt.core_en = !st_nxt.buf_w[scwol_pkg::BIT_CORE_PD]; // R12
        st_nxt.conv_pd = st_nxt.act[scwol_pkg::BIT_CONV_PD]; // R13
        st_nxt.ref_pd = st_nxt.buf_w[scwol_pkg::BIT_REF_PD]; // R14
        st_nxt.full_pd = pd_s &&
                         !st_nxt.act[scwol_pkg::BIT_EXT_FAST]; // R15
        st_nxt.fast_pd = pd_s &&
                         st_nxt.act[scwol_pkg::BIT_EXT_FAST]; // R15
    end

    // state register with documented defaults
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
            st_r.buf_w <= scwol_pkg::CF1_RESET;
            st_r.act <= scwol_pkg::CF1_RESET;
            st_r.sine <= 1'b1;
            st_r.core_en <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign sdio_out = st_r.sdio_out;
    assign sdio_oe = st_r.sdio_oe;
    assign sdo = st_r.sdo;
    assign sine_select = st_r.sine;
    assign ramp_rate_load = st_r.rr_load;
    assign ramp_acc_clear = st_r.ramp_clr;
    assign phase_acc_clear = st_r.phase_clr;
    assign keying_enable = st_r.key_en;
    assign keying_auto = st_r.key_auto;
    assign amp_adjust_enable = st_r.amp_adj;
    assign core_clock_enable = st_r.core_en;
    assign converter_powerdown = st_r.conv_pd;
    assign reference_input_powerdown = st_r.ref_pd;
    assign full_powerdown = st_r.full_pd;
    assign fast_powerdown = st_r.fast_pd;

    // checks on the transfer and output behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_ramp_autoclr_upd;
        xfer && st_r.buf_w[scwol_pkg::BIT_RAMP_AUTOCLR];
    endsequence

    sequence s_ramp_clear_held;
        ramp_acc_clear [*2];
    endsequence

    sequence s_reload_req;
        xfer && st_r.buf_w[scwol_pkg::BIT_RR_RELOAD] &&
            ramp_generator_enable;
    endsequence

    AST_SINE_SEL: // R1 R2
    assert property (xfer |=> sine_select ==
                     $past(st_r.buf_w[scwol_pkg::BIT_SINE]))
    else $error("sine select did not follow update");

    AST_RR_GATED: // R3
    assert property (ramp_rate_load |-> $past(ramp_generator_enable))
    else $error("ramp rate load without ramp generator");

    AST_RR_LOAD: // R4
    assert property (s_reload_req |=> ramp_rate_load ##1 !ramp_rate_load)
    else $error("ramp rate load pulse wrong");

    AST_RAMP_AUTO: // R5
    assert property (s_ramp_autoclr_upd |=> s_ramp_clear_held)
    else $error("ramp autoclear pulse too short");

    AST_NO_EARLY: // R6 R18
    assert property (!xfer |=> $stable(st_r.act))
    else $error("active control changed without update");

    AST_XFER_ON_SYNC: // R6
    assert property (xfer |-> sync_en)
    else $error("transfer off the sync edge");

    AST_PHASE_AUTO: // R7
    assert property (xfer && st_r.buf_w[scwol_pkg::BIT_PHASE_AUTOCLR] |=>
                     phase_acc_clear)
    else $error("phase autoclear missing");

    AST_RAMP_STATIC: // R8
    assert property (st_r.act[scwol_pkg::BIT_RAMP_CLR] && !xfer |=>
                     ramp_acc_clear)
    else $error("ramp static clear not held");

    AST_PHASE_STATIC: // R9
    assert property (st_r.act[scwol_pkg::BIT_PHASE_CLR] && !xfer |=>
                     phase_acc_clear)
    else $error("phase static clear not held");

    AST_KEY_AUTO: // R10
    assert property (keying_auto |-> keying_enable)
    else $error("auto keying without keying enable");

    AST_AMP_ADJ: // R11
    assert property (amp_adjust_enable == keying_enable)
    else $error("amplitude adjust not gated by keying");

    AST_CORE_PD: // R12
    assert property (1'b1 |=> core_clock_enable ==
                     !$past(st_nxt.buf_w[scwol_pkg::BIT_CORE_PD]))
    else $error("digital power-down not immediate");

    AST_CONV_PD: // R13
    assert property (1'b1 |=> converter_powerdown ==
                     $past(st_nxt.act[scwol_pkg::BIT_CONV_PD]))
    else $error("converter power-down mismatch");

    AST_REF_PD: // R14
    assert property (1'b1 |=> reference_input_powerdown ==
                     $past(st_nxt.buf_w[scwol_pkg::BIT_REF_PD]))
    else $error("reference power-down not immediate");

    AST_EXT_PD: // R15
    assert property (pd_s && !xfer |=>
                     (full_powerdown != fast_powerdown) &&
                     fast_powerdown == st_r.act[scwol_pkg::BIT_EXT_FAST])
    else $error("external power-down mode wrong");

    AST_SDIO_DIR: // R16
    assert property (sdio_oe |->
                     !st_r.act[scwol_pkg::BIT_SDIO_IN_ONLY] && st_r.rd)
    else $error("data line driven in three-wire mode");

    AST_RSVD: // R19
    assert property ((st_r.buf_w & ~scwol_pkg::CF1_WMASK) == 32'h0000_0000)
    else $error("unused bit stored");

endmodule

// *** scwol_host.sv ***
`timescale 1ns/10ps
// host controller model driving the serial port
module scwol_host (
    input wire logic clk,
    output logic sclk,
    output logic cs_b,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic sdo
);
    logic lsb = 1'b0;
    logic three_wire = 1'b0;
    logic host_d = 1'b0;

    initial
    begin
        sclk = 1'b0;
        cs_b = 1'b1;
    end

    // data line level: device drives it only while its enable is high
    always_comb sdio_in = sdio_oe ? sdio_out : host_d;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one frame: 8 instruction bits then 32 data bits, clock idle low
    task automatic frame(
        input logic rd,
        input logic [6:0] addr,
        input logic [31:0] wd,
        output logic [31:0] rdat
    );
        logic [7:0] ins;
        int b;
        ins = {rd, addr};
        rdat = 32'h0000_0000;
        tick(1);
        cs_b = 1'b0;
        for (int i = 0; i < 40; i++)
        begin
            b = (i < 8) ? (lsb ? i : 7 - i) : (lsb ? i - 8 : 39 - i);
            if (i < 8)
                host_d = ins[b];
            else if (!rd)
                host_d = wd[b];
            else
                host_d = ~host_d; // released line keeps changing
            tick(5);
            if (rd && i >= 8)
                rdat[b] = three_wire ? sdo : sdio_in;
            sclk = 1'b1;
            tick(5);
            sclk = 1'b0;
        end
        tick(5);
        cs_b = 1'b1;
        host_d = ~host_d;
        tick(10);
    endtask
endmodule

// *** test_synth_control_word_one_low.sv ***
`timescale 1ns/10ps
module test_synth_control_word_one_low;
    localparam int DIV = 5;
    localparam logic [6:0] AD = scwol_pkg::ADDR_CONTROL_FUNCTION_ONE;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic io_update = 1'b0;
    logic [2:0] profile_select = 3'h0;
    logic external_powerdown_pin = 1'b0;
    logic ramp_generator_enable = 1'b0;
    logic sclk, cs_b, sdio_in, sdio_out, sdio_oe, sdo;
    logic sine_select, ramp_rate_load, ramp_acc_clear, phase_acc_clear;
    logic keying_enable, keying_auto, amp_adjust_enable, core_clock_enable;
    logic converter_powerdown, reference_input_powerdown;
    logic full_powerdown, fast_powerdown;
    logic [31:0] rv;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    int n_load = 0;
    int n_ramp = 0;
    int n_phase = 0;

    scwol_ctrl #(.SYNC_DIV(DIV)) scwol_ctrl_i (.clk(clk), .rst_b(rst_b),
        .sclk(sclk), .cs_b(cs_b), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .sdo(sdo), .io_update(io_update),
        .profile_select(profile_select),
        .external_powerdown_pin(external_powerdown_pin),
        .ramp_generator_enable(ramp_generator_enable),
        .sine_select(sine_select), .ramp_rate_load(ramp_rate_load),
        .ramp_acc_clear(ramp_acc_clear), .phase_acc_clear(phase_acc_clear),
        .keying_enable(keying_enable), .keying_auto(keying_auto),
        .amp_adjust_enable(amp_adjust_enable),
        .core_clock_enable(core_clock_enable),
        .converter_powerdown(converter_powerdown),
        .reference_input_powerdown(reference_input_powerdown),
        .full_powerdown(full_powerdown), .fast_powerdown(fast_powerdown));

    scwol_host scwol_host_i (.clk(clk), .sclk(sclk), .cs_b(cs_b),
        .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo(sdo));

    // clock
    always #5 clk = ~clk;

    // pulse counters and hang limit, sampled mid-cycle where outputs settle
    always @(negedge clk)
    begin
        cyc++;
        n_load += (ramp_rate_load === 1'b1);
        n_ramp += (ramp_acc_clear === 1'b1);
        n_phase += (phase_acc_clear === 1'b1);
        if (cyc == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic clr();
        n_load = 0;
        n_ramp = 0;
        n_phase = 0;
    endtask

    // update strobe pulse, then let the transfer land
    task automatic upd();
        io_update = 1'b1;
        scwol_host_i.tick(3);
        io_update = 1'b0;
        scwol_host_i.tick(20);
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        scwol_host_i.tick(4);
        check(sine_select, 1'b1);
        check(core_clock_enable, 1'b1);
        scwol_host_i.frame(1'b1, AD, 32'h0000_0000, rv);
        check(rv, scwol_pkg::CF1_RESET);
        scwol_host_i.frame(1'b0, AD, 32'hFFFF_FFFF, rv);
        scwol_host_i.frame(1'b1, AD, 32'h0000_0000, rv);
        check(rv, scwol_pkg::CF1_WMASK);
        check(core_clock_enable, 1'b0);
        check(reference_input_powerdown, 1'b1);
        check({converter_powerdown, phase_acc_clear}, 2'b00);
        upd();
        check({keying_enable, keying_auto}, 2'b11);
        check(amp_adjust_enable, 1'b1);
        check(converter_powerdown, 1'b1);
        check(ramp_acc_clear, 1'b1);
        check(phase_acc_clear, 1'b1);
        // bits 1 and 0 are now active: three-wire, lsb first
        scwol_host_i.lsb = 1'b1;
        scwol_host_i.three_wire = 1'b1;
        scwol_host_i.frame(1'b1, AD, 32'h0000_0000, rv);
        check(rv, scwol_pkg::CF1_WMASK);
        scwol_host_i.frame(1'b0, AD, 32'h0000_020B, rv);
        upd();
        check({ramp_acc_clear, phase_acc_clear}, 2'b00);
        check(keying_auto, 1'b0);
        check(sine_select, 1'b0);
        check(core_clock_enable, 1'b1);
        external_powerdown_pin = 1'b1;
        scwol_host_i.tick(4);
        check({full_powerdown, fast_powerdown}, 2'b01);
        // autoclear and reload through a profile change
        scwol_host_i.frame(1'b0, AD, 32'h0000_E003, rv);
        ramp_generator_enable = 1'b1;
        clr();
        profile_select = 3'h1;
        scwol_host_i.tick(20);
        check(n_load, 1);
        check(n_ramp, DIV);
        check(n_phase, DIV);
        ramp_generator_enable = 1'b0;
        clr();
        upd();
        check(n_load, 0);
        check(n_ramp, DIV);
        // back to msb first, two-wire
        scwol_host_i.frame(1'b0, AD, 32'h0000_0000, rv);
        upd();
        scwol_host_i.lsb = 1'b0;
        scwol_host_i.three_wire = 1'b0;
        check({full_powerdown, fast_powerdown}, 2'b10);
        // a write to an unmapped address must leave the register alone
        scwol_host_i.frame(1'b0, 7'h05, 32'hFFFF_FFFF, rv);
        scwol_host_i.frame(1'b1, AD, 32'h0000_0000, rv);
        check(rv, 32'h0000_0000);
        scwol_host_i.frame(1'b0, AD, 32'h0001_0100, rv);
        scwol_host_i.frame(1'b1, AD, 32'h0000_0000, rv);
        check(rv, 32'h0001_0100);
        scwol_host_i.frame(1'b1, 7'h05, 32'h0000_0000, rv);
        check(rv, 32'h0000_0000);
        tally_and_finish();
    end
endmodule
